// ===== hdl/ctd_pkg.sv
// Purpose: Constants for the cable diagnostics control and result block
// Assumes: APB word per register, byte address is four times the index
// Notes:   Operation
// Operation
// RL1 - Writing one starts active-link test, self-clears
// RL2 - Active-link status bit reads one while running
// RL3 - Cross mode watches opposite pair unless disabled
// RL4 - Transmit-pair bypass skips transmit-pair reflectometry
// RL5 - Receive-pair bypass skips receive-pair reflectometry
// RL6 - Averaging code selects two-power reflectometry cycles
// RL7 - Pulse control sets expected self reflection
// RL8 - Cable-length field sets listening duration
// RL9 - Short-cable threshold compensates strong reflections
// RL10 - Five transmit-pair peak locations, read-only, packed
// RL11 - First receive-pair peak in upper byte, raw
// RL12 - Gain-retrain disable bit stops gain retraining
// RL13 - Results hold until next run completes
// RL14 - Software keeps reserved bits, polls before reading
package ctd_pkg;
  // Register indices as printed, byte address is four times these
  localparam logic [11:0] IDX_GAIN   = 12'h130;
  localparam logic [11:0] IDX_ALINK  = 12'h155;
  localparam logic [11:0] IDX_RCTL   = 12'h170;
  localparam logic [11:0] IDX_PULSE  = 12'h171;
  localparam logic [11:0] IDX_LISTEN = 12'h173;
  localparam logic [11:0] IDX_SHORT  = 12'h177;
  localparam logic [11:0] IDX_LOC1   = 12'h180;
  localparam logic [11:0] IDX_LOC2   = 12'h181;
  localparam logic [11:0] IDX_LOC3   = 12'h182;
  localparam logic [11:0] IDX_ISTAT  = 12'h1a0;
  localparam logic [11:0] IDX_IMASK  = 12'h1a1;
  localparam logic [11:0] IDX_RUN    = 12'h1a2;
  localparam int ADDR_W = 12;
  // Field positions
  localparam int B_GAIN_DIS   = 11;
  localparam int B_AL_START   = 15;
  localparam int B_AL_BUSY    = 12;
  localparam int B_AL_SUM_LO  = 4;
  localparam int B_CROSS_DIS  = 14;
  localparam int B_TX_BYP     = 13;
  localparam int B_RX_BYP     = 12;
  localparam int B_AVG_LO     = 8;
  localparam int B_LISTEN_LO  = 8;
  localparam int B_SHORT_LO   = 8;
  localparam int B_RUN_START  = 0;
  localparam int B_RUN_BUSY   = 1;
  localparam int I_ALINK_DONE = 0;
  localparam int I_TDR_DONE   = 1;
  // Reset values
  localparam logic [15:0] RST_GAIN   = 16'h0001;
  localparam logic [3:0]  RST_AL_LOW = 4'h1;
  localparam logic [15:0] RST_RCTL   = 16'h0e52;
  localparam logic [15:0] RST_PULSE  = 16'hc85c;
  localparam logic [15:0] RST_LISTEN = 16'hff1e;
  localparam logic [15:0] RST_SHORT  = 16'h189b;
  // Writable masks; bit 15 of the control register is read-only zero
  localparam logic [15:0] MSK_RCTL   = 16'h7fff;
  localparam logic [2:0]  AVG_RSVD   = 3'h7;
  localparam logic [6:0]  AVG_MAX    = 7'h40;
  localparam int N_TX_PEAKS = 5;
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_FIRE   = 2'b01,
    ST_LISTEN = 2'b10,
    ST_DONE   = 2'b11
  } ctd_state_t;
endpackage

// ===== hdl/ctd_top.sv
// Purpose: Cable diagnostics control, sequencing and result registers
// Assumes: Front end on core_clk; peaks reported during listen windows
// Notes:   Zero-wait APB slave, all outputs registered
//
// The APB slave port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module ctd_top (
  // Clock and reset
  input  wire logic                       core_clk,
  input  wire logic                       rstn,
  // APB slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [ctd_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  // Interrupt
  output logic                            irq,
  // Active-link test front end
  output logic                            alink_req,
  input  wire logic                       alink_ack,
  input  wire logic [7:0]                 active_link_sum_result,
  // Reflectometry front end
  output logic                            tdr_fire,
  output logic                            tdr_pair,
  output logic                            tdr_cross_dis,
  output logic      [3:0]                 tdr_pulse_ctl,
  output logic      [7:0]                 tdr_listen_len,
  output logic      [4:0]                 tdr_short_thr,
  input  wire logic                       peak_vld,
  input  wire logic                       peak_pair,
  input  wire logic [2:0]                 peak_num,
  input  wire logic [7:0]                 peak_loc,
  // Receiver control
  output logic                            gain_retrain_dis
);

  typedef struct packed {
    logic [31:0]         rd_data;
    logic                ready;
    logic                slverr;
    logic                irq;
    logic [15:0]         gain;
    logic [3:0]          al_low;
    logic                al_busy;
    logic                al_req;
    logic [7:0]          al_sum;
    logic [15:0]         rctl;
    logic [15:0]         pulse;
    logic [15:0]         listen;
    logic [15:0]         short_thr;
    logic [39:0]         loc_tx;
    logic [7:0]          loc_rx;
    logic [39:0]         sh_tx;
    logic [7:0]          sh_rx;
    logic [1:0]          istat;
    logic [1:0]          imask;
    ctd_pkg::ctd_state_t state;
    logic                pair;
    logic [6:0]          cyc;
    logic [7:0]          timer;
    logic                fire;
  } ctd_regs_t;

  ctd_regs_t st_ff;
  ctd_regs_t nxt_st;

  // Reserved code runs the longest average rather than none
  function automatic logic [6:0] avg_cycles(input logic [2:0] code);
    if (code == ctd_pkg::AVG_RSVD) begin
      return ctd_pkg::AVG_MAX;
    end
    return 7'(7'h01 << code);
  endfunction

  function automatic logic [11:0] byte_addr(input logic [11:0] idx);
    return 12'(idx << 2);
  endfunction

  function automatic logic is_mapped(input logic [11:0] a);
    logic hit;
    hit = 1'b0;
    if (a == byte_addr(ctd_pkg::IDX_GAIN) || a == byte_addr(ctd_pkg::IDX_ALINK) ||
        a == byte_addr(ctd_pkg::IDX_RCTL) || a == byte_addr(ctd_pkg::IDX_PULSE) ||
        a == byte_addr(ctd_pkg::IDX_LISTEN) || a == byte_addr(ctd_pkg::IDX_SHORT) ||
        a == byte_addr(ctd_pkg::IDX_LOC1) || a == byte_addr(ctd_pkg::IDX_LOC2) ||
        a == byte_addr(ctd_pkg::IDX_LOC3) || a == byte_addr(ctd_pkg::IDX_ISTAT) ||
        a == byte_addr(ctd_pkg::IDX_IMASK) || a == byte_addr(ctd_pkg::IDX_RUN)) begin
      hit = 1'b1;
    end
    return hit;
  endfunction

  function automatic logic [15:0] rd_mux(input ctd_regs_t s, input logic [11:0] a);
    logic [15:0] d;
    d = 16'h0000;
    if (a == byte_addr(ctd_pkg::IDX_GAIN)) begin
      d = s.gain;
    end else if (a == byte_addr(ctd_pkg::IDX_ALINK)) begin
      // Start bit always reads zero
      d = {3'h0, s.al_busy, s.al_sum, s.al_low}; // RL2
    end else if (a == byte_addr(ctd_pkg::IDX_RCTL)) begin
      d = s.rctl & ctd_pkg::MSK_RCTL;
    end else if (a == byte_addr(ctd_pkg::IDX_PULSE)) begin
      d = s.pulse;
    end else if (a == byte_addr(ctd_pkg::IDX_LISTEN)) begin
      d = s.listen;
    end else if (a == byte_addr(ctd_pkg::IDX_SHORT)) begin
      d = s.short_thr;
    end else if (a == byte_addr(ctd_pkg::IDX_LOC1)) begin
      d = s.loc_tx[15:0]; // RL10
    end else if (a == byte_addr(ctd_pkg::IDX_LOC2)) begin
      d = s.loc_tx[31:16]; // RL10
    end else if (a == byte_addr(ctd_pkg::IDX_LOC3)) begin
      d = {s.loc_rx, s.loc_tx[39:32]}; // RL11
    end else if (a == byte_addr(ctd_pkg::IDX_ISTAT)) begin
      d = {14'h0000, s.istat};
    end else if (a == byte_addr(ctd_pkg::IDX_IMASK)) begin
      d = {14'h0000, s.imask};
    end else if (a == byte_addr(ctd_pkg::IDX_RUN)) begin
      d = {14'h0000, s.state != ctd_pkg::ST_IDLE, 1'b0};
    end
    return d;
  endfunction

  always_comb begin
    logic        setup;
    logic        wr;
    logic [15:0] wd;
    logic [1:0]  ev;
    logic        tx_on;
    logic        rx_on;
    logic        last_cyc;
    setup    = 1'b0;
    wr       = 1'b0;
    wd       = 16'h0000;
    ev       = 2'b00;
    tx_on    = 1'b0;
    rx_on    = 1'b0;
    last_cyc = 1'b0;
    nxt_st   = st_ff;

    // APB: decode in setup, answer with pready in the first access cycle
    setup          = psel && !penable;
    wr             = psel && penable && st_ff.ready && pwrite && !st_ff.slverr;
    wd             = pwdata[15:0];
    nxt_st.ready   = setup;
    nxt_st.slverr  = setup && !is_mapped(paddr);
    nxt_st.rd_data = setup ? {16'h0000, rd_mux(st_ff, paddr)} : 32'h0000_0000;

    tx_on = !st_ff.rctl[ctd_pkg::B_TX_BYP]; // RL4
    rx_on = !st_ff.rctl[ctd_pkg::B_RX_BYP]; // RL5

    if (wr) begin
      if (paddr == byte_addr(ctd_pkg::IDX_GAIN)) begin
        nxt_st.gain = wd; // RL12
      end
      if (paddr == byte_addr(ctd_pkg::IDX_ALINK)) begin
        nxt_st.al_low = wd[3:0];
        // Start is a strobe, not stored; a start while busy is ignored
        if (wd[ctd_pkg::B_AL_START] && !st_ff.al_busy) begin // RL1
          nxt_st.al_busy = 1'b1; // RL2
          nxt_st.al_req  = 1'b1;
        end
      end
      if (paddr == byte_addr(ctd_pkg::IDX_RCTL)) begin
        nxt_st.rctl = wd & ctd_pkg::MSK_RCTL;
      end
      if (paddr == byte_addr(ctd_pkg::IDX_PULSE)) begin
        nxt_st.pulse = wd; // RL7
      end
      if (paddr == byte_addr(ctd_pkg::IDX_LISTEN)) begin
        nxt_st.listen = wd; // RL8
      end
      if (paddr == byte_addr(ctd_pkg::IDX_SHORT)) begin
        nxt_st.short_thr = wd; // RL9
      end
      if (paddr == byte_addr(ctd_pkg::IDX_ISTAT)) begin
        nxt_st.istat = st_ff.istat & ~wd[1:0];
      end
      if (paddr == byte_addr(ctd_pkg::IDX_IMASK)) begin
        nxt_st.imask = wd[1:0];
      end
    end

    // Active-link test completes on the front-end acknowledge
    if (st_ff.al_busy && alink_ack) begin
      nxt_st.al_busy = 1'b0; // RL2
      nxt_st.al_req  = 1'b0;
      nxt_st.al_sum  = active_link_sum_result;
      ev[ctd_pkg::I_ALINK_DONE] = 1'b1;
    end

    // Reflectometry sequencer
    nxt_st.fire = 1'b0;
    unique case (st_ff.state)
      ctd_pkg::ST_IDLE: begin
        if (wr && paddr == byte_addr(ctd_pkg::IDX_RUN) && wd[ctd_pkg::B_RUN_START]) begin
          // Shadows clear so a skipped pair reports zero locations
          nxt_st.sh_tx = 40'h00_0000_0000;
          nxt_st.sh_rx = 8'h00;
          nxt_st.cyc   = 7'h00;
          nxt_st.pair  = !tx_on; // RL4
          if (tx_on || rx_on) begin // RL5
            nxt_st.state = ctd_pkg::ST_FIRE;
          end else begin
            nxt_st.state = ctd_pkg::ST_DONE;
          end
        end
      end
      ctd_pkg::ST_FIRE: begin
        nxt_st.fire  = 1'b1;
        nxt_st.timer = st_ff.listen[15:8]; // RL8
        nxt_st.state = ctd_pkg::ST_LISTEN;
      end
      ctd_pkg::ST_LISTEN: begin
        // Opposite-pair reflections only count in cross mode
        if (peak_vld && (peak_pair == st_ff.pair ||
                         !st_ff.rctl[ctd_pkg::B_CROSS_DIS])) begin // RL3
          if (!peak_pair && peak_num < 3'(ctd_pkg::N_TX_PEAKS)) begin
            nxt_st.sh_tx[peak_num*8 +: 8] = peak_loc; // RL10
          end else if (peak_pair && peak_num == 3'h0) begin
            nxt_st.sh_rx = peak_loc; // RL11
          end
        end
        if (st_ff.timer != 8'h00) begin
          nxt_st.timer = st_ff.timer - 8'h01;
        end else begin
          last_cyc = (st_ff.cyc == avg_cycles(st_ff.rctl[ctd_pkg::B_AVG_LO +: 3]) - 7'h01); // RL6
          if (!last_cyc) begin
            nxt_st.cyc   = st_ff.cyc + 7'h01;
            nxt_st.state = ctd_pkg::ST_FIRE;
          end else if (!st_ff.pair && rx_on) begin
            nxt_st.cyc   = 7'h00;
            nxt_st.pair  = 1'b1; // RL5
            nxt_st.state = ctd_pkg::ST_FIRE;
          end else begin
            nxt_st.state = ctd_pkg::ST_DONE;
          end
        end
      end
      ctd_pkg::ST_DONE: begin
        nxt_st.loc_tx = st_ff.sh_tx; // RL13
        nxt_st.loc_rx = st_ff.sh_rx; // RL13
        nxt_st.state  = ctd_pkg::ST_IDLE;
        ev[ctd_pkg::I_TDR_DONE] = 1'b1;
      end
    endcase

    // New events win over a clear in the same cycle
    nxt_st.istat = nxt_st.istat | ev;
    nxt_st.irq   = |(nxt_st.istat & nxt_st.imask);
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      st_ff           <= '0;
      st_ff.gain      <= ctd_pkg::RST_GAIN;
      st_ff.al_low    <= ctd_pkg::RST_AL_LOW;
      st_ff.rctl      <= ctd_pkg::RST_RCTL;
      st_ff.pulse     <= ctd_pkg::RST_PULSE;
      st_ff.listen    <= ctd_pkg::RST_LISTEN;
      st_ff.short_thr <= ctd_pkg::RST_SHORT;
      st_ff.state     <= ctd_pkg::ST_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign prdata           = st_ff.rd_data;
  assign pready           = st_ff.ready;
  assign pslverr          = st_ff.slverr;
  assign irq              = st_ff.irq;
  assign alink_req        = st_ff.al_req;
  assign tdr_fire         = st_ff.fire;
  assign tdr_pair         = st_ff.pair;
  assign tdr_cross_dis    = st_ff.rctl[ctd_pkg::B_CROSS_DIS]; // RL3
  assign tdr_pulse_ctl    = st_ff.pulse[3:0]; // RL7
  assign tdr_listen_len   = st_ff.listen[15:8]; // RL8
  assign tdr_short_thr    = st_ff.short_thr[12:8]; // RL9
  assign gain_retrain_dis = st_ff.gain[ctd_pkg::B_GAIN_DIS]; // RL12

endmodule
`default_nettype wire

// ===== verif/ctd_chk_assertions.sv
// Purpose: Port assertions for the cable diagnostics block
// Assumes: Zero-wait APB slave, one clock domain
// Notes:   Bound into ctd_top below
`timescale 1ns/100ps
`default_nettype none
module ctd_chk (
  // Clock, reset and bus
  input wire logic        core_clk,
  input wire logic        rstn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Front end and receiver control
  input wire logic        alink_req,
  input wire logic        alink_ack,
  input wire logic        tdr_fire,
  input wire logic        tdr_cross_dis,
  input wire logic [3:0]  tdr_pulse_ctl,
  input wire logic        gain_retrain_dis
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  logic wr;
  assign wr = psel && penable && pready && pwrite;
  ready_after_setup_a: assert property (psel && !penable |=> pready && penable)
    else $error("no ready after setup");
  read_idle_zero_a: assert property (!pready |-> prdata == 32'h0 && !pslverr)
    else $error("read data or error outside access");
  alink_start_a: assert property (wr && paddr == 12'h554 && pwdata[15] && !alink_req |=> alink_req)
    else $error("test did not start");
  alink_no_start_a: assert property (wr && paddr == 12'h554 && !pwdata[15] && !alink_req
    |=> !alink_req) else $error("test started by zero");
  alink_hold_a: assert property (alink_req && !alink_ack |=> alink_req)
    else $error("test ended without answer");
  alink_end_a: assert property (alink_req && alink_ack |=> !alink_req)
    else $error("test still running after answer");
  fire_single_a: assert property ($rose(tdr_fire) |=> !tdr_fire)
    else $error("fire pulse too long");
  gain_copy_a: assert property (wr && paddr == 12'h4c0
    |-> ##2 gain_retrain_dis == $past(pwdata[11], 2)) else $error("gain disable wrong");
  cross_copy_a: assert property (wr && paddr == 12'h5c0
    |-> ##2 tdr_cross_dis == $past(pwdata[14], 2)) else $error("cross disable wrong");
  pulse_copy_a: assert property (wr && paddr == 12'h5c4
    |-> ##2 tdr_pulse_ctl == $past(pwdata[3:0], 2)) else $error("pulse control wrong");
endmodule
bind ctd_top ctd_chk u_chk (.core_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .alink_req, .alink_ack, .tdr_fire, .tdr_cross_dis,
  .tdr_pulse_ctl, .gain_retrain_dis);
`default_nettype wire

// ===== verif/ctd_line.sv
// Purpose: Cable and analog front end model
// Assumes: Peaks arrive two to six cycles after each fire, a stray one at seven when xpeak is set
// Notes:   Idle data lines show inverted values so stale captures stand out
`timescale 1ns/100ps
`default_nettype none
module ctd_line (
  // Clock, reset and test controls
  input  wire logic       core_clk,
  input  wire logic       rstn,
  input  wire logic       slow,
  input  wire logic       xpeak,
  // Active-link side
  input  wire logic       alink_req,
  output logic            alink_ack,
  output logic [7:0]      active_link_sum_result,
  // Reflectometry side
  input  wire logic       tdr_fire,
  input  wire logic       tdr_pair,
  output logic            peak_vld,
  output logic            peak_pair,
  output logic [2:0]      peak_num,
  output logic [7:0]      peak_loc
);
  logic [3:0] acnt;
  logic [3:0] pcnt;
  always_ff @(posedge core_clk) begin
    if (!rstn || !alink_req) acnt <= 4'h0;
    else if (acnt != 4'hf) acnt <= acnt + 4'h1;
    if (!rstn) pcnt <= 4'h0;
    else if (tdr_fire) pcnt <= 4'h1;
    else if (pcnt != 4'h0 && pcnt != 4'h8) pcnt <= pcnt + 4'h1;
    else pcnt <= 4'h0;
  end
  always_comb begin
    alink_ack = alink_req && (acnt == (slow ? 4'h6 : 4'h0));
    active_link_sum_result = alink_ack ? 8'h5a : 8'ha5;
    peak_vld = (pcnt >= 4'h2 && pcnt <= 4'h6) || (xpeak && pcnt == 4'h7);
    // Stray peak on the opposite pair must be dropped while cross mode is off
    peak_pair = (pcnt == 4'h7) ? !tdr_pair : tdr_pair;
    peak_num = (pcnt == 4'h7) ? 3'h0 : 3'(pcnt - 4'h2);
    peak_loc = (pcnt == 4'h7) ? 8'hee : {tdr_pair, peak_num, 4'h3};
    if (!peak_vld) begin
      peak_num = ~peak_num;
      peak_loc = ~peak_loc;
    end
  end
endmodule
`default_nettype wire

// ===== verif/cable_tdr_diagnostics_tb_top.sv
// Purpose: Register level bench for the cable diagnostics block
// Assumes: Zero-wait APB, model answers with fixed peak codes
// Notes:   Cross mode stays off except in the last run, where stray peaks must show
`timescale 1ns/100ps
`default_nettype none
module cable_tdr_diagnostics_tb_top;
  logic core_clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic slow = 1'b0, xpeak = 1'b1, err;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, irq, alink_req, alink_ack, tdr_fire, tdr_pair, tdr_cross_dis;
  logic gain_retrain_dis, peak_vld, peak_pair;
  logic [7:0] sum, tdr_listen_len, peak_loc;
  logic [3:0] tdr_pulse_ctl;
  logic [4:0] tdr_short_thr;
  logic [2:0] peak_num;
  int bad_count = 0, compares = 0, ntx = 0, nrx = 0;
  localparam logic [11:0] ridx [11] = '{ctd_pkg::IDX_GAIN, ctd_pkg::IDX_ALINK,
    ctd_pkg::IDX_RCTL, ctd_pkg::IDX_PULSE, ctd_pkg::IDX_LISTEN, ctd_pkg::IDX_SHORT,
    ctd_pkg::IDX_LOC1, ctd_pkg::IDX_LOC2, ctd_pkg::IDX_LOC3, ctd_pkg::IDX_ISTAT,
    ctd_pkg::IDX_IMASK};
  localparam logic [15:0] rexp [11] = '{16'h0001, 16'h0001, 16'h0e52, 16'hc85c, 16'hff1e,
    16'h189b, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0};
  // Control, mid-run loc1, loc1, loc2, loc3, transmit fires, receive fires
  // Last run enables cross mode, so a stray opposite-pair peak overwrites the first transmit-pair peak
  localparam logic [95:0] runs [6] = '{
    {16'h4852, 16'h0000, 16'h1303, 16'h3323, 16'h8343, 8'd1, 8'd1},
    {16'h6b52, 16'h1303, 16'h0000, 16'h0000, 16'h8300, 8'd0, 8'd8},
    {16'h5a52, 16'h0000, 16'h1303, 16'h3323, 16'h0043, 8'd4, 8'd0},
    {16'h6f52, 16'h1303, 16'h0000, 16'h0000, 16'h8300, 8'd0, 8'd64},
    {16'h7852, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 8'd0, 8'd0},
    {16'h0852, 16'h0000, 16'h13ee, 16'h3323, 16'h8343, 8'd1, 8'd1}};
  always #10 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    if (tdr_fire === 1'b1 && tdr_pair === 1'b0) ntx++;
    if (tdr_fire === 1'b1 && tdr_pair === 1'b1) nrx++;
  end
  ctd_top DUT (.core_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .irq, .alink_req, .alink_ack, .active_link_sum_result(sum),
    .tdr_fire, .tdr_pair, .tdr_cross_dis, .tdr_pulse_ctl, .tdr_listen_len, .tdr_short_thr,
    .peak_vld, .peak_pair, .peak_num, .peak_loc, .gain_retrain_dis);
  ctd_line u_line (.core_clk, .rstn, .slow, .xpeak, .alink_req, .alink_ack,
    .active_link_sum_result(sum), .tdr_fire, .tdr_pair, .peak_vld, .peak_pair, .peak_num,
    .peak_loc);
  task automatic xfer(input logic [11:0] idx, input logic w, input logic [15:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx[9:0], 2'b00};
    pwdata <= {16'h0, d};
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic rdc(input logic [11:0] idx, input logic [15:0] e);
    xfer(idx, 1'b0, 16'h0);
    chk(rd[15:0], e);
  endtask
  task automatic poll(input logic [11:0] idx, input int b);
    int n;
    n = 0;
    do begin
      xfer(idx, 1'b0, 16'h0);
      n++;
    end while (rd[b] !== 1'b0 && n < 2000);
    chk(16'(n < 2000), 16'h1);
  endtask
  task automatic run(input logic [15:0] c, input logic [7:0] tx, rx, input logic [15:0] m);
    xfer(ctd_pkg::IDX_RCTL, 1'b1, c);
    ntx = 0;
    nrx = 0;
    xfer(ctd_pkg::IDX_RUN, 1'b1, 16'h0001);
    rdc(ctd_pkg::IDX_LOC1, m);
    poll(ctd_pkg::IDX_RUN, 1);
    chk(16'(ntx), {8'h0, tx});
    chk(16'(nrx), {8'h0, rx});
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic irq_is(input logic e);
    @(negedge core_clk);
    chk({15'h0, irq}, {15'h0, e});
  endtask
  initial begin
    repeat (60000) @(posedge core_clk);
    bad_count++;
    $display("wrong value at %0t: watchdog expired", $time);
    conclude();
  end
  initial begin
    repeat (6) @(posedge core_clk);
    rstn <= 1'b1;
    foreach (ridx[i]) rdc(ridx[i], rexp[i]);
    chk({tdr_pulse_ctl, 3'h0, tdr_short_thr, 2'h0, tdr_cross_dis, gain_retrain_dis}, 16'hc180);
    chk({tdr_listen_len, 8'h0}, 16'hff00);
    $display("test reset values done");
    xfer(ctd_pkg::IDX_GAIN, 1'b1, 16'h0801);
    xfer(ctd_pkg::IDX_PULSE, 1'b1, 16'hc853);
    xfer(ctd_pkg::IDX_LISTEN, 1'b1, 16'h091e);
    xfer(ctd_pkg::IDX_SHORT, 1'b1, 16'h059b);
    xfer(ctd_pkg::IDX_RCTL, 1'b1, 16'hc852);
    rdc(ctd_pkg::IDX_RCTL, 16'h4852);
    rdc(ctd_pkg::IDX_GAIN, 16'h0801);
    chk({tdr_pulse_ctl, 3'h0, tdr_short_thr, 2'h0, tdr_cross_dis, gain_retrain_dis}, 16'h3053);
    chk({tdr_listen_len, 8'h0}, 16'h0900);
    rdc(12'h1ff, 16'h0);
    chk({15'h0, err}, 16'h1);
    xfer(ctd_pkg::IDX_LOC1, 1'b1, 16'hffff);
    rdc(ctd_pkg::IDX_LOC1, 16'h0);
    $display("test config done");
    xfer(ctd_pkg::IDX_IMASK, 1'b1, 16'h0001);
    slow <= 1'b1;
    xfer(ctd_pkg::IDX_ALINK, 1'b1, 16'h8001);
    rdc(ctd_pkg::IDX_ALINK, 16'h1001);
    poll(ctd_pkg::IDX_ALINK, 12);
    chk(rd[15:0], 16'h05a1);
    irq_is(1'b1);
    xfer(ctd_pkg::IDX_ISTAT, 1'b1, 16'h0001);
    irq_is(1'b0);
    xfer(ctd_pkg::IDX_ALINK, 1'b1, 16'h0001);
    rdc(ctd_pkg::IDX_ALINK, 16'h05a1);
    chk({15'h0, alink_req}, 16'h0);
    $display("test active link done");
    foreach (runs[i]) begin
      run(runs[i][95:80], runs[i][15:8], runs[i][7:0], runs[i][79:64]);
      rdc(ctd_pkg::IDX_LOC1, runs[i][63:48]);
      rdc(ctd_pkg::IDX_LOC2, runs[i][47:32]);
      rdc(ctd_pkg::IDX_LOC3, runs[i][31:16]);
    end
    irq_is(1'b0);
    rdc(ctd_pkg::IDX_ISTAT, 16'h0002);
    xfer(ctd_pkg::IDX_IMASK, 1'b1, 16'h0003);
    irq_is(1'b1);
    xfer(ctd_pkg::IDX_ISTAT, 1'b1, 16'h0002);
    irq_is(1'b0);
    $display("test reflectometry done");
    conclude();
  end
endmodule
`default_nettype wire
